// ---- pkg/tbp_regs.svh ----
`ifndef TBP_REGS_SVH
`define TBP_REGS_SVH
// ----------------------------------------
// register map (index; byte address is four times index)
// ----------------------------------------
`define TBP_IDX_DATA 8'h07
`define TBP_IDX_DIR 8'h0a
`define TBP_IDX_FUNC 8'h0b
`define TBP_ADDR_DATA 12'h01c
`define TBP_ADDR_DIR 12'h028
`define TBP_ADDR_FUNC 12'h02c
`define TBP_RST_LATCH 3'h7
`define TBP_RST_DIR 1'h0
`define TBP_RST_FUNC 3'h0
`define TBP_BIT_RD 0
`define TBP_BIT_WR 1
`define TBP_BIT_HWR 2
`endif

// ---- pkg/tbp_pkg.sv ----
package tbp_pkg;
   typedef struct packed {
      logic rd_active;
      logic wr_active;
      logic hwr_active;
      logic external;
   } tbp_cycle_s;
   typedef struct packed {
      logic [2:0] latch;
      logic dir2;
      logic [2:0] func;
   } tbp_cfg_s;
endpackage

// ---- rtl/tbp_port.sv ----
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "tbp_regs.svh"
module tbp_port (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // bus cycle status from the cpu, same clock
   input wire tbp_pkg::tbp_cycle_s cycle,
   input wire logic pin2_in,
   output logic pin0_out,
   output logic pin1_out,
   output logic pin2_out,
   output logic pin2_oe,
   output logic pin2_pullup
);
   // ----------------------------------------
   // register state
   // ----------------------------------------
   tbp_pkg::tbp_cfg_s cfg_reg, cfg_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pslverr_reg, pslverr_next;
   logic pready_reg, pready_next;
   logic sync1_reg, sync2_reg;
   logic access;
   logic hit;

   assign access = psel & penable & ~pready_reg;
   assign hit = (paddr == `TBP_ADDR_DATA) | (paddr == `TBP_ADDR_DIR) | (paddr == `TBP_ADDR_FUNC);

   // pin input passes two flops; only the second is read
   // reset high: the pull-up is on after reset, so a low here would be a false level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
      end else begin
         sync1_reg <= pin2_in;
         sync2_reg <= sync1_reg;
      end
   end

   // one wait state: answer registered, pready high in second access cycle
   always_comb begin
      cfg_next = cfg_reg;
      prdata_next = prdata_reg;
      pslverr_next = 1'b0;
      pready_next = access;
      if (access) begin
         prdata_next = 32'h0;
         pslverr_next = ~hit;
         if (pwrite) begin
            case (paddr)
               `TBP_ADDR_DATA: cfg_next.latch = pwdata[2:0];
               `TBP_ADDR_DIR: cfg_next.dir2 = pwdata[2];
               `TBP_ADDR_FUNC: cfg_next.func = pwdata[2:0];
               default: ;
            endcase
         end else if (paddr == `TBP_ADDR_DATA) begin
            // pin two reads the pin while input; write-only registers read zero
            prdata_next = {29'h0, (cfg_reg.dir2 ? cfg_reg.latch[2] : sync2_reg), cfg_reg.latch[1:0]};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg <= {`TBP_RST_LATCH, `TBP_RST_DIR, `TBP_RST_FUNC};
         prdata_reg <= 32'h0;
         pslverr_reg <= 1'b0;
         pready_reg <= 1'b0;
      end else begin
         cfg_reg <= cfg_next;
         prdata_reg <= prdata_next;
         pslverr_reg <= pslverr_next;
         pready_reg <= pready_next;
      end
   end

   assign prdata = prdata_reg;
   assign pslverr = pslverr_reg;
   assign pready = pready_reg;

   // ----------------------------------------
   // pin drivers, registered
   // ----------------------------------------
   logic p0_reg;
   logic p0_next;
   logic p1_reg;
   logic p1_next;
   logic p2_reg;
   logic p2_next;
   logic oe_reg;
   logic oe_next;
   logic pu_reg;
   logic pu_next;

   always_comb begin
      p0_next = cfg_reg.latch[0];
      if (cfg_reg.func[`TBP_BIT_RD]) begin
         if (!cfg_reg.latch[0])
            p0_next = ~cycle.rd_active;
         else
            p0_next = ~(cycle.rd_active & cycle.external);
      end
      if (cfg_reg.func[`TBP_BIT_WR])
         p1_next = ~(cycle.wr_active & cycle.external);
      else
         p1_next = cfg_reg.latch[1];
      oe_next = cfg_reg.dir2;
      if (cfg_reg.func[`TBP_BIT_HWR] & cfg_reg.dir2)
         p2_next = ~(cycle.hwr_active & cycle.external);
      else
         p2_next = cfg_reg.latch[2];
      pu_next = ~cfg_reg.dir2 & cfg_reg.latch[2];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         p0_reg <= 1'b1;
         p1_reg <= 1'b1;
         p2_reg <= 1'b1;
         oe_reg <= 1'b0;
         pu_reg <= 1'b1;
      end else begin
         p0_reg <= p0_next;
         p1_reg <= p1_next;
         p2_reg <= p2_next;
         oe_reg <= oe_next;
         pu_reg <= pu_next;
      end
   end

   assign pin0_out = p0_reg;
   assign pin1_out = p1_reg;
   assign pin2_out = p2_reg;
   assign pin2_oe = oe_reg;
   assign pin2_pullup = pu_reg;
endmodule

// ---- dv/tbp_port_sva.sv ----
`timescale 1ns/1ps
module tbp_port_sva(input wire logic pclk,presetn,psel,penable,pwrite,pready,pslverr,pin0_out,pin1_out,
   input wire logic pin2_out,pin2_oe,pin2_pullup,input wire logic [11:0] paddr,input wire logic [31:0] pwdata,
   input wire tbp_pkg::tbp_cycle_s cycle);
   // shadow of the written config; the block reads back only the data latch, not direction or function
   logic [2:0] lt,fn;
   logic dr;
   always_ff @(posedge pclk or negedge presetn) if(!presetn) {lt,fn,dr}<=7'h70;
      else if(psel&&penable&&pready&&pwrite&&!pslverr) begin
      if(paddr==12'h01c) lt<=pwdata[2:0];
      if(paddr==12'h028) dr<=pwdata[2];
      if(paddr==12'h02c) fn<=pwdata[2:0];
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_bad_addr: assert property (pready |-> pslverr==!(paddr inside {12'h01c,12'h028,12'h02c})) else $error("err");
   a_reset_pins: assert property ($rose(presetn) |-> pin0_out&&pin1_out&&!pin2_oe&&pin2_pullup) else $error("rst");
   a_rd_strobe: assert property (pin0_out==(fn[0]?!($past(cycle.rd_active)&&($past(cycle.external)||!lt[0])):lt[0]))
      else $error("rd");
   a_wr_strobe: assert property (pin1_out==(fn[1]?!($past(cycle.wr_active)&&$past(cycle.external)):lt[1]))
      else $error("wr");
   a_pin2_dir: assert property (pin2_oe==dr) else $error("oe");
   a_pin2_latch: assert property (dr&&!fn[2] |-> pin2_out==lt[2]) else $error("p2");
   a_hwr_idle: assert property (dr&&fn[2]&&!$past(cycle.hwr_active) |-> pin2_out) else $error("hwr");
   a_pullup_ctl: assert property (!dr |-> pin2_pullup==lt[2]) else $error("pu");
endmodule
bind tbp_port tbp_port_sva chk(.*);

// ---- dv/tbp_ext_pin.sv ----
`timescale 1ns/1ps
module tbp_ext_pin(input wire logic pclk,oe,dout,pu,drv,dval,output logic pin);
   logic lv;
   always_ff @(posedge pclk) lv <= pin;
   // a floating pad flips each cycle so a stale level never passes
   assign pin = oe ? dout : drv ? dval : pu ? 1'b1 : ~lv;
endmodule

// ---- dv/three_bit_port_with_bus_strobes_tb.sv ----
`timescale 1ns/1ps
module three_bit_port_with_bus_strobes_tb;
   logic pclk=0,presetn=0,psel=0,penable=0,pwrite=0,drv=0,err,pin2_in,pin0_out,pin1_out,pin2_out,pin2_oe,pin2_pullup;
   logic pready,pslverr;
   logic [11:0] paddr=12'h0;
   logic [31:0] pwdata=32'h0,prdata,rd;
   tbp_pkg::tbp_cycle_s cycle='0;
   int n_fail=0,checks_done=0;
   // latch, direction, function, cycle {rd,wr,hwr,ext}, expected {pin0,pin1,pad,oe}
   logic [16:0] rows[9]='{{3'h7,3'h3,3'h0,4'h0,4'he},{3'h6,3'h0,3'h0,4'h0,4'h6},{3'h1,3'h4,3'h0,4'h0,4'h9},
      {3'h6,3'h0,3'h1,4'h8,4'h6},{3'h7,3'h0,3'h1,4'h8,4'he},{3'h7,3'h0,3'h1,4'h9,4'h6},
      {3'h7,3'h0,3'h2,4'h5,4'ha},{3'h7,3'h4,3'h4,4'h3,4'hd},{3'h7,3'h0,3'h4,4'h3,4'he}};
   always #2 pclk=~pclk;
   tbp_port dut(.*);
   tbp_ext_pin ext(.pclk,.oe(pin2_oe),.dout(pin2_out),.pu(pin2_pullup),.drv,.dval(1'b0),.pin(pin2_in));
   task chk(input string s,input logic [31:0] g,e);
      checks_done++;
      if(g!==e) begin n_fail++; $display("unexpected %s exp %h seen %h",s,e,g); end
   endtask
   task print_verdict;
      $display("fails %0d checks %0d",n_fail,checks_done);
      if(n_fail==0&&checks_done>0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task apb(input logic w,input logic [11:0] a,input logic [31:0] d);
      int n;
      @(posedge pclk) {psel,pwrite,paddr,pwdata}<={1'b1,w,a,d};
      @(posedge pclk) penable<=1;
      for(n=0;pready!==1'b1;n++) begin @(posedge pclk); if(n>20) begin n_fail++; print_verdict; end end
      rd=prdata;
      err=pslverr;
      {psel,penable}<=2'h0;
   endtask
   initial begin
      logic [2:0] l,dr,f;
      logic [3:0] c,e;
      repeat(3) @(posedge pclk);
      presetn<=1;
      foreach(rows[i]) begin
         {l,dr,f,c,e}=rows[i];
         apb(1,12'h01c,{29'h0,l});
         apb(1,12'h028,{29'h0,dr});
         apb(1,12'h02c,{29'h0,f});
         cycle<=c;
         repeat(2) @(posedge pclk);
         #1 chk("pins",{pin0_out,pin1_out,pin2_in,pin2_oe},e);
      end
      cycle<='0;
      apb(0,12'h028,32'h0); chk("dir",rd,32'h0);
      apb(0,12'h030,32'h0); chk("err",err,1'h1);
      @(posedge pclk) presetn<=0;
      repeat(3) @(posedge pclk);
      presetn<=1;
      #1 chk("rst",{pin0_out,pin1_out,pin2_oe,pin2_pullup},4'hd);
      apb(0,12'h01c,32'h0); chk("data",rd,32'h7);
      drv<=1;
      apb(1,12'h01c,32'h3);
      repeat(4) @(posedge pclk);
      apb(0,12'h01c,32'h0); chk("pad",rd,32'h3);
      chk("pullup",pin2_pullup,1'h0);
      print_verdict;
   end
endmodule
